// ### rtl/pioc_pkg.sv
package pioc_pkg;
   // Port widths
   localparam int TRI_W   = 3;   // Globally steered port
   localparam int OCT_W   = 8;   // Bit-steered port
   localparam int IN_W    = 3;   // Input-only port
   localparam int REQ_W   = 4;   // Edge requests zero to three
   // Input-only line positions
   localparam int LN_CMP1 = 0;   // First comparator signal input
   localparam int LN_CMP2 = 1;   // Second comparator signal input
   localparam int LN_REF  = 2;   // Shared reference line
   // Request positions
   localparam int RQ_ZERO  = 0;
   localparam int RQ_ONE   = 1;
   localparam int RQ_TWO   = 2;
   localparam int RQ_THREE = 3;
   // Reset values of the mode controls
   localparam logic             TRI_DIR_RST = 1'h1;     // Tri port inputs after reset
   localparam logic [OCT_W-1:0] OCT_DIR_RST = 8'hff;    // Octal port inputs after reset
   localparam logic             OCT_OD_RST  = 1'h1;     // Octal port open drain after reset
   localparam logic             ANA_RST     = 1'h0;     // Digital input mode after reset
   localparam logic             KEEP_DEF    = 1'h1;     // Keeper latches on by default
   // Synchroniser output sense
   typedef enum logic [1:0] {PIOC_EDGE_FALL, PIOC_EDGE_RISE, PIOC_EDGE_ANY} pioc_edge_t;
endpackage : pioc_pkg

// ### rtl/pioc_edge_if.sv
`timescale 1ns/1ps
`default_nettype none
// Carries a raw level into the edge detector and the qualified level and edges out
interface pioc_edge_if;
   logic raw;    // Asynchronous level
   logic lvl;    // Synchronised level
   logic rise;   // One-cycle rising pulse
   logic fall;   // One-cycle falling pulse
   modport src (output raw, input lvl, input rise, input fall);
   modport det (input raw, output lvl, output rise, output fall);
endinterface : pioc_edge_if
`default_nettype wire

// ### rtl/pioc_edge.sv
`timescale 1ns/1ps
`default_nettype none
// Three-flop synchroniser with edge detection from the last two stages
module pioc_edge
   import pioc_pkg::*;
(
   // Clock and reset
   input wire logic  I_CLK,
   input wire logic  I_NRST,
   // Edge carrier
   pioc_edge_if.det  e
);
   logic [2:0] sh_q;   // Stage 0 only feeds stage 1
   logic [2:0] sh_d;
   logic       st_q;   // Last agreed level
   logic       st_d;

   // Shift in and accept a change once stages one and two agree
   always_comb begin
      sh_d = {sh_q[1:0], e.raw};
      st_d = st_q;
      if (sh_q[1] == sh_q[2]) begin
         st_d = sh_q[2];
      end
   end

   always_ff @(posedge I_CLK) begin
      if (!I_NRST) begin
         // Keep sampling through reset so the agreed level matches the line on release;
         // a fixed zero here would report a false rising edge on lines that idle high
         sh_q <= sh_d;
         st_q <= sh_q[2];
      end else begin
         sh_q <= sh_d;
         st_q <= st_d;
      end
   end

   // Each qualified change produces exactly one pulse
   assign e.lvl  = st_q;
   assign e.rise = st_d & ~st_q & I_NRST;
   assign e.fall = ~st_d & st_q & I_NRST;
endmodule : pioc_edge
`default_nettype wire

// ### rtl/pioc_port.sv
`timescale 1ns/1ps
`default_nettype none
module pioc_port
   import pioc_pkg::*;
#(
   parameter logic KEEP_EN = KEEP_DEF   // Build option for keeper latches
)(
   // Clock and reset
   input  wire logic             I_CLK,
   input  wire logic             I_NRST,
   // Core control
   input  wire logic             I_TRI_DIR_IN,    // 1: whole tri port is input
   input  wire logic [OCT_W-1:0] I_OCT_DIR_IN,    // 1: line is input
   input  wire logic             I_OCT_OD,        // 1: open drain, 0: push-pull
   input  wire logic             I_ANALOG,        // 1: comparators active
   input  wire logic             I_STOP,          // Stop standby mode
   input  wire logic             I_CFG_WE,        // Loads the four controls above, not I_STOP
   input  wire logic [TRI_W-1:0] I_TRI_OUT,       // Tri port output data
   input  wire logic [OCT_W-1:0] I_OCT_OUT,       // Octal port output data
   input  wire logic [REQ_W-1:0] I_REQ_CLR,       // Clears request flags
   // Tri port pins
   input  wire logic [TRI_W-1:0] I_TRI_PIN,
   output logic      [TRI_W-1:0] O_TRI_PIN,
   output logic      [TRI_W-1:0] O_TRI_OE_N,
   // Octal port pins
   input  wire logic [OCT_W-1:0] I_OCT_PIN,
   output logic      [OCT_W-1:0] O_OCT_PIN,
   output logic      [OCT_W-1:0] O_OCT_OE_N,
   // Input-only lines: digital level and comparator results
   input  wire logic [IN_W-1:0]  I_IN_PIN,
   input  wire logic             I_CMP1_RAW,      // Analog first input above reference
   input  wire logic             I_CMP2_RAW,      // Analog second input above reference
   // Results to the core
   output logic      [TRI_W-1:0] O_TRI_DATA,
   output logic      [OCT_W-1:0] O_OCT_DATA,
   output logic      [IN_W-1:0]  O_IN_DATA,
   output logic      [REQ_W-1:0] O_REQ,           // Sticky edge request flags
   output logic                  O_TIMER_IN,      // External timer input
   output logic                  O_CMP_PWR,       // Comparator power enable
   output logic                  O_KEEP_EN        // Keeper latch enable
);
   // Mode registers
   logic             tri_dir_q, tri_dir_d;
   logic [OCT_W-1:0] oct_dir_q, oct_dir_d;
   logic             oct_od_q,  oct_od_d;
   logic             ana_q,     ana_d;
   // Pin drive registers
   logic [TRI_W-1:0] tri_o_q, tri_o_d, tri_oe_q, tri_oe_d;
   logic [OCT_W-1:0] oct_o_q, oct_o_d, oct_oe_q, oct_oe_d;
   // Data, keepers and flags
   logic [TRI_W-1:0] tri_k_q, tri_k_d;
   logic [OCT_W-1:0] oct_k_q, oct_k_d;
   logic [IN_W-1:0]  in_q,    in_d;
   logic [REQ_W-1:0] req_q,   req_d;
   logic             tin_q,   tin_d;
   logic             pwr_q,   pwr_d;
   // Synchronised input-only lines and comparators
   logic [IN_W-1:0]  in_lvl, in_rise, in_fall;
   logic             c1_lvl, c1_fall, c2_rise, c2_fall, c2_lvl;
   logic             cmp_on;
   // Synchronised bidirectional pin levels
   logic [TRI_W-1:0] tri_lvl;
   logic [OCT_W-1:0] oct_lvl;

   // One synchroniser per input-only line
   generate
      for (genvar g = 0; g < IN_W; g++) begin : g_in
         pioc_edge_if ei ();
         assign ei.raw = I_IN_PIN[g];
         pioc_edge u_e (.I_CLK(I_CLK), .I_NRST(I_NRST), .e(ei));
         assign in_lvl[g]  = ei.lvl;
         assign in_rise[g] = ei.rise;
         assign in_fall[g] = ei.fall;
      end
   endgenerate

   // Board pins are asynchronous, so each readback passes three flops as well;
   // the cost is a few cycles of extra read latency on the port data
   generate
      for (genvar g = 0; g < TRI_W; g++) begin : g_tri
         pioc_edge_if ep ();
         assign ep.raw = I_TRI_PIN[g];
         pioc_edge u_e (.I_CLK(I_CLK), .I_NRST(I_NRST), .e(ep));
         assign tri_lvl[g] = ep.lvl;
      end
      for (genvar g = 0; g < OCT_W; g++) begin : g_oct
         pioc_edge_if ep ();
         assign ep.raw = I_OCT_PIN[g];
         pioc_edge u_e (.I_CLK(I_CLK), .I_NRST(I_NRST), .e(ep));
         assign oct_lvl[g] = ep.lvl;
      end
   endgenerate

   // Comparator outputs come from analog cells, so they are synchronised too
   pioc_edge_if ec1 ();
   pioc_edge_if ec2 ();
   assign ec1.raw = I_CMP1_RAW & cmp_on;
   assign ec2.raw = I_CMP2_RAW & cmp_on;
   pioc_edge u_c1 (.I_CLK(I_CLK), .I_NRST(I_NRST), .e(ec1));
   pioc_edge u_c2 (.I_CLK(I_CLK), .I_NRST(I_NRST), .e(ec2));
   assign c1_lvl  = ec1.lvl;
   assign c1_fall = ec1.fall;
   assign c2_lvl  = ec2.lvl;
   assign c2_rise = ec2.rise;
   assign c2_fall = ec2.fall;

   // Comparators run only in analog mode and never in stop
   assign cmp_on = ana_q & ~I_STOP;

   // Mode control next state
   always_comb begin
      tri_dir_d = tri_dir_q;
      oct_dir_d = oct_dir_q;
      oct_od_d  = oct_od_q;
      ana_d     = ana_q;
      if (I_CFG_WE) begin
         tri_dir_d = I_TRI_DIR_IN;
         oct_dir_d = I_OCT_DIR_IN;
         oct_od_d  = I_OCT_OD;
         ana_d     = I_ANALOG;
      end
   end

   // Pin drive next state; enables are low while driving
   always_comb begin
      tri_o_d  = I_TRI_OUT;
      tri_oe_d = {TRI_W{tri_dir_q}};   // One setting for all three lines
      oct_o_d  = I_OCT_OUT;
      for (int i = 0; i < OCT_W; i++) begin
         // Per-line direction open drain only drives low
         oct_oe_d[i] = oct_dir_q[i] | (oct_od_q & I_OCT_OUT[i]);
      end
   end

   // Input data, keepers, requests and timer input
   always_comb begin
      // Keeper on: input lines read the pin and output lines their output register; keeper off: all lines read the pin
      tri_k_d = tri_k_q;
      oct_k_d = oct_k_q;
      if (KEEP_EN) begin
         tri_k_d = tri_dir_q ? tri_lvl : tri_o_q;
         for (int i = 0; i < OCT_W; i++) begin
            oct_k_d[i] = oct_dir_q[i] ? oct_lvl[i] : oct_o_q[i];
         end
      end else begin
         tri_k_d = tri_lvl;
         oct_k_d = oct_lvl;
      end
      // Input-only data: comparator results in analog mode
      in_d = in_lvl;
      if (ana_q) begin
         in_d[LN_CMP1] = c1_lvl;
         in_d[LN_CMP2] = c2_lvl;
      end
      // Sticky flags; a new edge wins over a clear
      req_d = req_q & ~I_REQ_CLR;
      if (ana_q) begin
         req_d[RQ_ZERO]  = req_d[RQ_ZERO]  | c1_fall;
         req_d[RQ_TWO]   = req_d[RQ_TWO]   | c2_rise | c2_fall;
      end else begin
         req_d[RQ_ZERO]  = req_d[RQ_ZERO]  | in_fall[LN_CMP1];
         req_d[RQ_TWO]   = req_d[RQ_TWO]   | in_fall[LN_CMP2];
         // Reference line free as a digital request source
         req_d[RQ_ONE]   = req_d[RQ_ONE]   | in_fall[LN_REF];
      end
      // Rising edge of the first line feeds request three
      req_d[RQ_THREE] = req_d[RQ_THREE] | in_rise[LN_CMP1];
      // Timer input from first line or first comparator
      tin_d = ana_q ? c1_lvl : in_lvl[LN_CMP1];
      pwr_d = cmp_on;
   end

   // Registers
   always_ff @(posedge I_CLK) begin
      if (!I_NRST) begin
         tri_dir_q <= TRI_DIR_RST;
         oct_dir_q <= OCT_DIR_RST;
         oct_od_q  <= OCT_OD_RST;
         ana_q     <= ANA_RST;
         tri_o_q   <= '0;
         tri_oe_q  <= '1;
         oct_o_q   <= '0;
         oct_oe_q  <= '1;
         // Keeper content after reset is a don't-care for software
         tri_k_q   <= '0;
         oct_k_q   <= '0;
         in_q      <= '0;
         req_q     <= '0;
         tin_q     <= 1'h0;
         pwr_q     <= 1'h0;
      end else begin
         tri_dir_q <= tri_dir_d;
         oct_dir_q <= oct_dir_d;
         oct_od_q  <= oct_od_d;
         ana_q     <= ana_d;
         tri_o_q   <= tri_o_d;
         tri_oe_q  <= tri_oe_d;
         oct_o_q   <= oct_o_d;
         oct_oe_q  <= oct_oe_d;
         tri_k_q   <= tri_k_d;
         oct_k_q   <= oct_k_d;
         in_q      <= in_d;
         req_q     <= req_d;
         tin_q     <= tin_d;
         pwr_q     <= pwr_d;
      end
   end

   // Outputs straight from flip-flops, except the keeper enable, which is the KEEP_EN parameter
   assign O_TRI_PIN  = tri_o_q;
   assign O_TRI_OE_N = tri_oe_q;
   assign O_OCT_PIN  = oct_o_q;
   assign O_OCT_OE_N = oct_oe_q;
   assign O_TRI_DATA = tri_k_q;
   assign O_OCT_DATA = oct_k_q;
   assign O_IN_DATA  = in_q;
   assign O_REQ      = req_q;
   assign O_TIMER_IN = tin_q;
   assign O_CMP_PWR  = pwr_q;
   assign O_KEEP_EN  = KEEP_EN;
endmodule : pioc_port
`default_nettype wire

// ### tb/pioc_port_sva.sv
`timescale 1ns/1ps
`default_nettype none
// Watches pin drive, comparator power and request flags at the block's ports
module pioc_port_chk
   import pioc_pkg::*;
(
   input wire logic             I_CLK,
   input wire logic             I_NRST,
   input wire logic             I_TRI_DIR_IN,
   input wire logic [OCT_W-1:0] I_OCT_DIR_IN,
   input wire logic             I_OCT_OD,
   input wire logic             I_STOP,
   input wire logic             I_CFG_WE,
   input wire logic [REQ_W-1:0] I_REQ_CLR,
   input wire logic [IN_W-1:0]  I_IN_PIN,
   input wire logic             I_CMP2_RAW,
   input wire logic [TRI_W-1:0] O_TRI_OE_N,
   input wire logic [OCT_W-1:0] O_OCT_PIN,
   input wire logic [OCT_W-1:0] O_OCT_OE_N,
   input wire logic [REQ_W-1:0] O_REQ,
   input wire logic             O_CMP_PWR,
   input wire logic             O_KEEP_EN
);
   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (!I_NRST);
   // Line zero rises and then holds long enough to count once
   sequence s_rise0;
      $rose(I_IN_PIN[0]) ##1 I_IN_PIN[0] [*3];
   endsequence
   // Second comparator toggles while powered, then holds
   sequence s_cmp2_edge;
      (O_CMP_PWR && !I_STOP && $changed(I_CMP2_RAW)) ##1 (O_CMP_PWR && !I_STOP && $stable(I_CMP2_RAW)) [*3];
   endsequence
   property p_keep_on;    O_KEEP_EN;                                                  endproperty
   property p_tri_same;   O_TRI_OE_N == 3'h0 || O_TRI_OE_N == 3'h7;                   endproperty
   // Mode loads at the strobe edge and the drive registers follow one edge later
   property p_tri_dir;    I_CFG_WE |-> ##2 O_TRI_OE_N == {3{$past(I_TRI_DIR_IN, 2)}};   endproperty
   property p_oct_pp;     (I_CFG_WE && !I_OCT_OD) |-> ##2 O_OCT_OE_N == $past(I_OCT_DIR_IN, 2); endproperty
   property p_oct_od;     (I_CFG_WE && I_OCT_OD) |-> ##2 (~O_OCT_OE_N & O_OCT_PIN) == 8'h00; endproperty
   property p_stop_pwr;   I_STOP |=> !O_CMP_PWR;                                      endproperty
   property p_rise_req;   s_rise0 |-> ##[1:3] O_REQ[RQ_THREE];                         endproperty
   property p_cmp2_req;   s_cmp2_edge |-> ##[1:3] O_REQ[RQ_TWO];                       endproperty
   property p_clr_once;   (I_IN_PIN[0] [*8] ##0 I_REQ_CLR[RQ_THREE]) |=> !O_REQ[RQ_THREE]; endproperty
   a_keep_on:  assert property (p_keep_on)  else $error("keeper enable low");
   a_tri_same: assert property (p_tri_same) else $error("tri lines split");
   a_tri_dir:  assert property (p_tri_dir)  else $error("tri direction wrong");
   a_oct_pp:   assert property (p_oct_pp)   else $error("octal direction wrong");
   a_oct_od:   assert property (p_oct_od)   else $error("open drain drives high");
   a_stop_pwr: assert property (p_stop_pwr) else $error("comparators on in stop");
   a_rise_req: assert property (p_rise_req) else $error("rise request missing");
   a_cmp2_req: assert property (p_cmp2_req) else $error("comparator two request missing");
   a_clr_once: assert property (p_clr_once) else $error("request set twice");
endmodule : pioc_port_chk
bind pioc_port pioc_port_chk u_chk (.I_CLK, .I_NRST, .I_TRI_DIR_IN, .I_OCT_DIR_IN, .I_OCT_OD, .I_STOP,
   .I_CFG_WE, .I_REQ_CLR, .I_IN_PIN, .I_CMP2_RAW, .O_TRI_OE_N, .O_OCT_PIN, .O_OCT_OE_N, .O_REQ,
   .O_CMP_PWR, .O_KEEP_EN);
`default_nettype wire

// ### tb/pioc_board.sv
`timescale 1ns/1ps
`default_nettype none
// Board side of a port: the block wins where it drives, the board level elsewhere
module pioc_board #(
   parameter int W = 8   // Port width
)(
   input  wire logic [W-1:0] i_drv,    // Block drive value
   input  wire logic [W-1:0] i_oe_n,   // Block enables, low drives
   input  wire logic [W-1:0] i_ext,    // Board level on released lines
   output logic      [W-1:0] o_pin     // Resolved wire
);
   // Released lines never echo the last drive, so a stuck enable shows up
   always_comb o_pin = (i_drv & ~i_oe_n) | (i_ext & i_oe_n);
endmodule : pioc_board
`default_nettype wire

// ### tb/pioc_port_tb.sv
`timescale 1ns/1ps
`default_nettype none
module pioc_port_tb;
   import pioc_pkg::*;
   logic       clk = 1'b0, nrst = 1'b0, tri_dir = 1'b1, oct_od = 1'b1, ana = 1'b0, stp = 1'b0, we = 1'b0;
   logic       cmp1 = 1'b0, cmp2 = 1'b0, tmr, cmp_pwr, keep;
   logic [2:0] tri_out = 3'h0, tri_pin, tri_pin_o, tri_oe_n, in_pin = 3'h7, tri_data, in_data;
   logic [7:0] oct_dir = 8'hff, oct_out = 8'h00, oct_ext = 8'hf0, oct_pin, oct_pin_o, oct_oe_n, oct_data;
   logic [3:0] req_clr = 4'h0, req;
   int         err_total = 0, check_count = 0;
   // Free running 50 MHz core clock
   always #10 clk = ~clk;
   pioc_port u_dut (.I_CLK(clk), .I_NRST(nrst), .I_TRI_DIR_IN(tri_dir), .I_OCT_DIR_IN(oct_dir),
      .I_OCT_OD(oct_od), .I_ANALOG(ana), .I_STOP(stp), .I_CFG_WE(we), .I_TRI_OUT(tri_out),
      .I_OCT_OUT(oct_out), .I_REQ_CLR(req_clr), .I_TRI_PIN(tri_pin), .O_TRI_PIN(tri_pin_o),
      .O_TRI_OE_N(tri_oe_n), .I_OCT_PIN(oct_pin), .O_OCT_PIN(oct_pin_o), .O_OCT_OE_N(oct_oe_n),
      .I_IN_PIN(in_pin), .I_CMP1_RAW(cmp1), .I_CMP2_RAW(cmp2), .O_TRI_DATA(tri_data),
      .O_OCT_DATA(oct_data), .O_IN_DATA(in_data), .O_REQ(req), .O_TIMER_IN(tmr), .O_CMP_PWR(cmp_pwr),
      .O_KEEP_EN(keep));
   // Board models; tri lines see the inverse of the drive when released
   pioc_board #(.W(3)) u_tri (.i_drv(tri_pin_o), .i_oe_n(tri_oe_n), .i_ext(~tri_out), .o_pin(tri_pin));
   pioc_board #(.W(8)) u_oct (.i_drv(oct_pin_o), .i_oe_n(oct_oe_n), .i_ext(oct_ext), .o_pin(oct_pin));
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : step
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : wrap_up
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("BAD t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   // One-cycle load strobe, then the drive settles and the pin readback clears its synchroniser
   task automatic cfg(input logic td, input logic [7:0] od, input logic dd, input logic an);
      tri_dir = td; oct_dir = od; oct_od = dd; ana = an; we = 1'b1;
      step(1);
      we = 1'b0;
      step(7);
   endtask : cfg
   task automatic clear;
      req_clr = 4'hf;
      step(1);
      req_clr = 4'h0;
      step(1);
   endtask : clear
   // Apply input levels, wait for the flag (or a quiet spell), compare, then clear
   task automatic ev(input logic [2:0] p, input logic c1, input logic c2, input logic [3:0] exp);
      int i;
      in_pin = p; cmp1 = c1; cmp2 = c2;
      for (i = 0; i < 10; i++) begin
         if (exp != 4'h0 && req != 4'h0) break;
         step(1);
      end
      if (i == 10 && exp != 4'h0) begin
         err_total++;
         wrap_up();
      end
      chk({4'h0, req}, {4'h0, exp});
      clear();
   endtask : ev
   task automatic t_reset;
      chk({5'h0, tri_oe_n}, 8'h07);
      chk(oct_oe_n, 8'hff);
      chk({4'h0, req}, 8'h00);
      chk({5'h0, in_data}, 8'h07);
      chk({7'h0, keep}, 8'h01);
      $display("reset test done");
   endtask : t_reset
   task automatic t_ports;
      tri_out = 3'h5; oct_out = 8'h0f;
      cfg(1'b0, 8'h5a, 1'b0, 1'b0);
      chk({5'h0, tri_oe_n}, 8'h00);
      chk({5'h0, tri_data}, 8'h05);
      chk(oct_oe_n, 8'h5a);
      chk(oct_data, 8'h55);
      chk({5'h0, tri_pin_o}, 8'h05);
      chk(oct_pin_o, 8'h0f);
      oct_ext = 8'hff;
      cfg(1'b1, 8'h00, 1'b1, 1'b0);
      chk({5'h0, tri_oe_n}, 8'h07);
      chk(oct_oe_n, 8'h0f);
      chk(oct_data, 8'h0f);
      chk({5'h0, tri_data}, 8'h02);
      $display("port test done");
   endtask : t_ports
   task automatic t_digital;
      clear();
      ev(3'h6, 1'b0, 1'b0, 4'h1);
      chk({7'h0, tmr}, 8'h00);
      ev(3'h2, 1'b0, 1'b0, 4'h2);
      ev(3'h0, 1'b0, 1'b0, 4'h4);
      ev(3'h1, 1'b0, 1'b0, 4'h8);
      chk({7'h0, tmr}, 8'h01);
      ev(3'h7, 1'b0, 1'b0, 4'h0);
      $display("digital test done");
   endtask : t_digital
   task automatic t_analog;
      cfg(1'b1, 8'hff, 1'b1, 1'b1);
      chk({7'h0, cmp_pwr}, 8'h01);
      clear();
      ev(3'h7, 1'b1, 1'b0, 4'h0);
      chk({7'h0, in_data[0]}, 8'h01);
      chk({7'h0, tmr}, 8'h01);
      ev(3'h7, 1'b0, 1'b0, 4'h1);
      chk({7'h0, tmr}, 8'h00);
      ev(3'h7, 1'b0, 1'b1, 4'h4);
      ev(3'h7, 1'b0, 1'b0, 4'h4);
      ev(3'h3, 1'b0, 1'b0, 4'h0);
      stp = 1'b1;
      step(2);
      chk({7'h0, cmp_pwr}, 8'h00);
      stp = 1'b0;
      cfg(1'b1, 8'hff, 1'b1, 1'b0);
      ev(3'h7, 1'b0, 1'b0, 4'h0);
      ev(3'h3, 1'b0, 1'b0, 4'h2);
      $display("analog test done");
   endtask : t_analog
   initial begin
      step(16);
      nrst = 1'b1;
      step(4);
      t_reset();
      t_ports();
      t_digital();
      t_analog();
      wrap_up();
   end
endmodule : pioc_port_tb
`default_nettype wire
